// >>> pabdma_ctrl.sv
/*
 * Two queued PCI-to-AHB DMA request buffers with their transfer engine:
 * register file written from the AHB side and read from both sides,
 * a PCI word fetch port, a two-entry data buffer and an AHB store port.
 * Assumes all ports are synchronous to I_CLOCK; the PCI and AHB bus
 * engines outside move the words and answer with valid/ready.
 */
`include "pabdma_regs.svh"
`default_nettype none
module pabdma_ctrl
   import pabdma_pkg::*;
#(
   parameter int DEPTH = 2
) (
   // clock and reset
   input  wire logic              I_CLOCK,
   input  wire logic              I_NRST,
   // AHB register access
   input  wire logic              I_AHB_SEL,
   input  wire logic              I_AHB_WRITE,
   input  wire logic [31:0]       I_AHB_ADDR,
   input  wire logic [31:0]       I_AHB_WDATA,
   output logic      [31:0]       O_AHB_RDATA,
   // PCI register read
   input  wire logic              I_PCI_SEL,
   input  wire logic [31:0]       I_PCI_ADDR,
   output logic      [31:0]       O_PCI_RDATA,
   output logic                   O_PCI_RVALID,
   // PCI word fetch
   output logic                   O_FETCH_VALID,
   output pabdma_fetch_type       O_FETCH,
   input  wire logic              I_FETCH_READY,
   input  wire logic              I_FETCH_DVALID,
   input  wire logic [31:0]       I_FETCH_DATA,
   output logic                   O_FETCH_DREADY,
   // AHB word store
   output logic                   O_STORE_VALID,
   output pabdma_store_type       O_STORE,
   input  wire logic              I_STORE_READY,
   // status
   output logic                   O_BUSY,
   output logic                   O_ACTIVE_BUF
);

   localparam int PW = $clog2(DEPTH);

   function automatic pabdma_decode_type decode(input logic [31:0] a);
      pabdma_decode_type d;
      d = '{hit: 1'b1, buf_idx: 1'b0, field: PABDMA_F_DST};
      if (a == `PABDMA_BUF0_DST_OFS) begin
         d.field = PABDMA_F_DST;
      end else if (a == `PABDMA_BUF0_SRC_OFS) begin
         d.field = PABDMA_F_SRC;
      end else if (a == `PABDMA_BUF0_LEN_OFS) begin
         d.field = PABDMA_F_LEN;
      end else if (a == `PABDMA_BUF1_DST_OFS) begin
         d.buf_idx = 1'b1;
         d.field   = PABDMA_F_DST;
      end else if (a == `PABDMA_BUF1_SRC_OFS) begin
         d.buf_idx = 1'b1;
         d.field   = PABDMA_F_SRC;
      end else if (a == `PABDMA_BUF1_LEN_OFS) begin
         d.buf_idx = 1'b1;
         d.field   = PABDMA_F_LEN;
      end else begin
         d.hit = 1'b0;
      end
      return d;
   endfunction

   function automatic logic [31:0] swap32(input logic [31:0] w);
      return {w[7:0], w[15:8], w[23:16], w[31:24]};
   endfunction

   // register state, both buffers
   logic [31:2] dst_q [2];
   logic [31:2] dst_d [2];
   logic [31:2] src_q [2];
   logic [31:2] src_d [2];
   logic [15:0] cnt_q [2];
   logic [15:0] cnt_d [2];
   logic        en_q  [2];
   logic        en_d  [2];
   logic        swp_q [2];
   logic        swp_d [2];

   // engine state
   pabdma_state_type state_q, state_d;
   logic        sel_q, sel_d;
   logic [31:0] run_src_q, run_src_d;
   logic [31:0] run_dst_q, run_dst_d;
   logic [15:0] run_cnt_q, run_cnt_d;
   logic        run_swp_q, run_swp_d;
   logic [15:0] fetched_q, fetched_d;
   logic [15:0] stored_q, stored_d;
   logic [PW:0] pending_q, pending_d;

   // two-entry data buffer
   logic [31:0]   ent_q [DEPTH];
   logic [31:0]   ent_d [DEPTH];
   logic [PW-1:0] wr_ptr_q, wr_ptr_d;
   logic [PW-1:0] rd_ptr_q, rd_ptr_d;
   logic [PW:0]   occ_q, occ_d;

   logic [31:0] ahb_rdata_d, pci_rdata_d;
   logic        pci_rvalid_d;

   pabdma_decode_type ahb_dec, pci_dec;
   logic        push, pop, fetch_go, done;

   function automatic logic [31:0] read_reg(input pabdma_decode_type d,
                                            input logic [31:2] dst,
                                            input logic [31:2] src,
                                            input logic        en,
                                            input logic        swp,
                                            input logic [15:0] cnt);
      logic [31:0] v;
      v = 32'h0000_0000;
      if (!d.hit) begin
         v = 32'h0000_0000;
      end else if (d.field == PABDMA_F_DST) begin
         v = {dst, 2'b00}; // see RULE1
      end else if (d.field == PABDMA_F_SRC) begin
         v = {src, 2'b00}; // see RULE2
      end else begin
         v[`PABDMA_EN_BIT]       = en;
         v[`PABDMA_SWAP_BIT]     = swp;
         v[`PABDMA_CNT_MSB:0]    = cnt; // see RULE8
      end
      return v;
   endfunction

   assign ahb_dec = decode(I_AHB_ADDR);
   assign pci_dec = decode(I_PCI_ADDR);

   // handshakes
   assign push           = I_FETCH_DVALID && O_FETCH_DREADY;
   assign pop            = O_STORE_VALID && I_STORE_READY;
   assign O_FETCH_DREADY = (occ_q != (PW+1)'(DEPTH));
   assign O_STORE_VALID  = (occ_q != '0);
   // no fetch unless buffer space is reserved for its word
   assign O_FETCH_VALID  = (state_q == PABDMA_RUN) &&
                           (fetched_q != run_cnt_q) &&
                           ((pending_q + occ_q) < (PW+1)'(DEPTH));
   assign fetch_go       = O_FETCH_VALID && I_FETCH_READY;
   assign done           = pop && (stored_q + 16'h0001 == run_cnt_q);

   assign O_FETCH.addr   = run_src_q + {14'h0000, fetched_q, 2'b00};
   assign O_STORE.addr   = run_dst_q + {14'h0000, stored_q, 2'b00};
   assign O_STORE.data   = ent_q[rd_ptr_q];
   assign O_BUSY         = (state_q == PABDMA_RUN);
   assign O_ACTIVE_BUF   = sel_q;

   // register file and engine next state
   always_comb begin
      dst_d        = dst_q;
      src_d        = src_q;
      cnt_d        = cnt_q;
      en_d         = en_q;
      swp_d        = swp_q;
      state_d      = state_q;
      sel_d        = sel_q;
      run_src_d    = run_src_q;
      run_dst_d    = run_dst_q;
      run_cnt_d    = run_cnt_q;
      run_swp_d    = run_swp_q;
      fetched_d    = fetched_q;
      stored_d     = stored_q;
      pending_d    = pending_q;
      ahb_rdata_d  = O_AHB_RDATA;
      pci_rdata_d  = O_PCI_RDATA;
      pci_rvalid_d = 1'b0;

      case (state_q)
         PABDMA_IDLE: begin
            // first buffer wins; second waits its turn (see RULE11)
            if (en_q[0] && cnt_q[0] != 16'h0000) begin // see RULE4
               sel_d   = 1'b0;
               state_d = PABDMA_RUN;
            end else if (en_q[1] && cnt_q[1] != 16'h0000) begin // see RULE3
               sel_d   = 1'b1;
               state_d = PABDMA_RUN;
            end else if (en_q[0]) begin
               en_d[0] = 1'b0;
            end else if (en_q[1]) begin
               en_d[1] = 1'b0;
            end
            run_src_d = {src_q[sel_d], 2'b00};
            run_dst_d = {dst_q[sel_d], 2'b00};
            run_cnt_d = cnt_q[sel_d]; // see RULE7
            run_swp_d = swp_q[sel_d];
            fetched_d = 16'h0000;
            stored_d  = 16'h0000;
            pending_d = '0;
         end
         PABDMA_RUN: begin
            if (fetch_go) begin
               fetched_d = fetched_q + 16'h0001;
            end
            pending_d = pending_q + (PW+1)'(fetch_go) - (PW+1)'(push);
            if (pop) begin
               stored_d = stored_q + 16'h0001;
            end
            if (done) begin
               en_d[sel_q] = 1'b0; // see RULE5
               state_d     = PABDMA_IDLE;
            end
         end
         default: begin
            state_d = PABDMA_IDLE;
         end
      endcase

      // AHB side writes after the hardware clear, so a set wins
      if (I_AHB_SEL && I_AHB_WRITE && ahb_dec.hit) begin // see RULE10
         if (ahb_dec.field == PABDMA_F_DST) begin
            dst_d[ahb_dec.buf_idx] = I_AHB_WDATA[31:`PABDMA_ADDR_LSB];
         end else if (ahb_dec.field == PABDMA_F_SRC) begin
            src_d[ahb_dec.buf_idx] = I_AHB_WDATA[31:`PABDMA_ADDR_LSB];
         end else begin
            en_d[ahb_dec.buf_idx]  = I_AHB_WDATA[`PABDMA_EN_BIT];
            swp_d[ahb_dec.buf_idx] = I_AHB_WDATA[`PABDMA_SWAP_BIT];
            cnt_d[ahb_dec.buf_idx] = I_AHB_WDATA[`PABDMA_CNT_MSB:0];
         end
      end
      if (I_AHB_SEL && !I_AHB_WRITE) begin
         ahb_rdata_d = read_reg(ahb_dec, dst_q[ahb_dec.buf_idx],
                                src_q[ahb_dec.buf_idx],
                                en_q[ahb_dec.buf_idx],
                                swp_q[ahb_dec.buf_idx],
                                cnt_q[ahb_dec.buf_idx]); // see RULE9
      end
      // PCI side only ever reads
      if (I_PCI_SEL) begin // see RULE10
         pci_rvalid_d = 1'b1;
         pci_rdata_d  = read_reg(pci_dec, dst_q[pci_dec.buf_idx],
                                 src_q[pci_dec.buf_idx],
                                 en_q[pci_dec.buf_idx],
                                 swp_q[pci_dec.buf_idx],
                                 cnt_q[pci_dec.buf_idx]);
      end
   end

   always_ff @(posedge I_CLOCK or negedge I_NRST) begin
      if (!I_NRST) begin
         for (int i = 0; i < 2; i++) begin
            dst_q[i] <= `PABDMA_ADDR_RESET;
            src_q[i] <= `PABDMA_ADDR_RESET;
            cnt_q[i] <= `PABDMA_CNT_RESET;
            en_q[i]  <= 1'b0;
            swp_q[i] <= 1'b0;
         end
         state_q      <= PABDMA_IDLE;
         sel_q        <= 1'b0;
         run_src_q    <= 32'h0000_0000;
         run_dst_q    <= 32'h0000_0000;
         run_cnt_q    <= `PABDMA_CNT_RESET;
         run_swp_q    <= 1'b0;
         fetched_q    <= 16'h0000;
         stored_q     <= 16'h0000;
         pending_q    <= '0;
         O_AHB_RDATA  <= 32'h0000_0000;
         O_PCI_RDATA  <= 32'h0000_0000;
         O_PCI_RVALID <= 1'b0;
      end else begin
         dst_q        <= dst_d;
         src_q        <= src_d;
         cnt_q        <= cnt_d;
         en_q         <= en_d;
         swp_q        <= swp_d;
         state_q      <= state_d;
         sel_q        <= sel_d;
         run_src_q    <= run_src_d;
         run_dst_q    <= run_dst_d;
         run_cnt_q    <= run_cnt_d;
         run_swp_q    <= run_swp_d;
         fetched_q    <= fetched_d;
         stored_q     <= stored_d;
         pending_q    <= pending_d;
         O_AHB_RDATA  <= ahb_rdata_d;
         O_PCI_RDATA  <= pci_rdata_d;
         O_PCI_RVALID <= pci_rvalid_d;
      end
   end

   // data buffer next state
   always_comb begin
      ent_d    = ent_q;
      wr_ptr_d = wr_ptr_q;
      rd_ptr_d = rd_ptr_q;
      occ_d    = occ_q + (PW+1)'(push) - (PW+1)'(pop);
      if (push) begin
         ent_d[wr_ptr_q] = run_swp_q ? swap32(I_FETCH_DATA)
                                     : I_FETCH_DATA; // see RULE6
         wr_ptr_d        = wr_ptr_q + PW'(1);
      end
      if (pop) begin
         rd_ptr_d = rd_ptr_q + PW'(1);
      end
   end

   always_ff @(posedge I_CLOCK or negedge I_NRST) begin
      if (!I_NRST) begin
         for (int i = 0; i < DEPTH; i++) begin
            ent_q[i] <= 32'h0000_0000;
         end
         wr_ptr_q <= '0;
         rd_ptr_q <= '0;
         occ_q    <= '0;
      end else begin
         ent_q    <= ent_d;
         wr_ptr_q <= wr_ptr_d;
         rd_ptr_q <= rd_ptr_d;
         occ_q    <= occ_d;
      end
   end

endmodule
`default_nettype wire

// >>> pabdma_ctrl_sva.sv
/*
 * Concurrent checks on the ports of the DMA request buffer block.
 * Assumes one clock domain and binding onto pabdma_ctrl.
 */
`default_nettype none
module pabdma_ctrl_sva
   import pabdma_pkg::*;
#(
   parameter int DEPTH = 2
) (
   // clock and reset
   input wire logic             I_CLOCK,
   input wire logic             I_NRST,
   // register access
   input wire logic             I_AHB_SEL,
   input wire logic             I_AHB_WRITE,
   input wire logic [31:0]      I_AHB_ADDR,
   input wire logic [31:0]      I_AHB_WDATA,
   input wire logic [31:0]      O_AHB_RDATA,
   input wire logic             I_PCI_SEL,
   input wire logic [31:0]      I_PCI_ADDR,
   input wire logic [31:0]      O_PCI_RDATA,
   input wire logic             O_PCI_RVALID,
   // data path
   input wire logic             O_FETCH_VALID,
   input wire pabdma_fetch_type O_FETCH,
   input wire logic             I_FETCH_READY,
   input wire logic             O_STORE_VALID,
   input wire pabdma_store_type O_STORE,
   input wire logic             I_STORE_READY,
   input wire logic             O_BUSY
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge I_CLOCK);
   endclocking
   default disable iff (!I_NRST);

   sequence s_rd(logic [31:0] a);
      I_AHB_SEL && !I_AHB_WRITE && I_AHB_ADDR == a;
   endsequence
   sequence s_go;
      I_AHB_SEL && I_AHB_WRITE && I_AHB_ADDR == 32'hC000_006C
         && I_AHB_WDATA[31] && I_AHB_WDATA[15:0] != 16'h0000 && !O_BUSY;
   endsequence
   sequence s_take;
      O_FETCH_VALID && I_FETCH_READY ##1 O_FETCH_VALID;
   endsequence

   a_dst_low: assert property (s_rd(32'hC000_0064) |=>
      O_AHB_RDATA[1:0] == 2'b00) else $error("dest low bits set");
   a_src_low: assert property (s_rd(32'hC000_0068) |=>
      O_AHB_RDATA[1:0] == 2'b00) else $error("source low bits set");
   a_len_rsvd: assert property (s_rd(32'hC000_006C) |=>
      O_AHB_RDATA[30:29] == 2'b00 && O_AHB_RDATA[27:16] == 12'h000)
      else $error("reserved length bits set");
   a_pci_len: assert property (I_PCI_SEL &&
      I_PCI_ADDR == 32'hC000_006C |=> O_PCI_RVALID &&
      O_PCI_RDATA[30:29] == 2'b00 && O_PCI_RDATA[27:16] == 12'h000)
      else $error("pci length read wrong");
   a_pci_hold: assert property (!O_PCI_RVALID |->
      $stable(O_PCI_RDATA)) else $error("pci read data moved");
   a_start_run: assert property (s_go |-> ##2 O_BUSY)
      else $error("enabled buffer did not start");
   a_idle_fetch: assert property (!O_BUSY |-> !O_FETCH_VALID)
      else $error("fetch while idle");
   a_fetch_step: assert property (s_take |->
      O_FETCH.addr == $past(O_FETCH.addr) + 32'h0000_0004)
      else $error("fetch address step wrong");
   a_fetch_hold: assert property (O_FETCH_VALID && !I_FETCH_READY
      |=> O_FETCH_VALID && $stable(O_FETCH)) else $error("fetch dropped");
   a_store_hold: assert property (O_STORE_VALID && !I_STORE_READY
      |=> O_STORE_VALID && $stable(O_STORE)) else $error("store dropped");
   a_store_align: assert property (O_STORE_VALID |->
      O_STORE.addr[1:0] == 2'b00) else $error("store unaligned");
endmodule

bind pabdma_ctrl pabdma_ctrl_sva #(.DEPTH(DEPTH)) u_sva (.I_CLOCK, .I_NRST,
   .I_AHB_SEL, .I_AHB_WRITE, .I_AHB_ADDR, .I_AHB_WDATA, .O_AHB_RDATA,
   .I_PCI_SEL, .I_PCI_ADDR, .O_PCI_RDATA, .O_PCI_RVALID, .O_FETCH_VALID,
   .O_FETCH, .I_FETCH_READY, .O_STORE_VALID, .O_STORE, .I_STORE_READY,
   .O_BUSY);
`default_nettype wire

// >>> pabdma_mem.sv
/*
 * Far side model: PCI word source answering fetches in order, and an
 * AHB store sink. Assumes stall bits from the bench, one clock.
 */
`default_nettype none
module pabdma_mem (
   // clock, reset and stall
   input  wire logic        i_clk,
   input  wire logic        i_nrst,
   input  wire logic [1:0]  i_stall,
   // fetch side
   input  wire logic        i_fvalid,
   input  wire logic [31:0] i_faddr,
   output logic             o_fready,
   output logic             o_dvalid,
   output logic [31:0]      o_data,
   input  wire logic        i_dready,
   // store side
   output logic             o_sready
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [31:0] pq[$];
   logic [31:0] w = 32'h0000_0000;
   logic        v = 1'b0;

   // pci side only answers reads, never writes registers
   always @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         pq.delete();
         v <= 1'b0;
      end else begin
         if (v && i_dready)
            void'(pq.pop_front());
         if (i_fvalid && o_fready)
            pq.push_back(i_faddr);
         v <= pq.size() != 0 && ((v && !i_dready) || !i_stall[0]);
         if (pq.size() != 0)
            w <= pq[0];
      end
   end
   assign o_dvalid = v;
   // released data line shows a scrambled pattern
   assign o_data = v ? {~w[15:0], w[15:0]} : {w[15:0], ~w[15:0]};
   assign o_fready = !i_stall[0];
   assign o_sready = !i_stall[1];
endmodule
`default_nettype wire

// >>> pabdma_pkg.sv
/*
 * Types shared by the DMA request buffer design.
 * Assumes pabdma_regs.svh is on the include path.
 */
`default_nettype none
package pabdma_pkg;
   typedef enum logic [1:0] {
      PABDMA_IDLE = 2'b01,
      PABDMA_RUN  = 2'b10
   } pabdma_state_type;

   typedef enum logic [1:0] {
      PABDMA_F_DST = 2'b00,
      PABDMA_F_SRC = 2'b01,
      PABDMA_F_LEN = 2'b10
   } pabdma_field_type;

   typedef struct packed {
      logic             hit;
      logic             buf_idx;
      pabdma_field_type field;
   } pabdma_decode_type;

   typedef struct packed {
      logic [31:0] addr;
   } pabdma_fetch_type;

   typedef struct packed {
      logic [31:0] addr;
      logic [31:0] data;
   } pabdma_store_type;
endpackage
`default_nettype wire

// >>> pabdma_regs.svh
/*
 * Register offsets, field positions and reset values of the two
 * PCI-to-AHB DMA request buffers.
 * Assumes inclusion by bare name before the package and the design.
 */
// Function
// RULE1 - destination address keeps bits 31:2, bits 1:0 always read zero
// RULE2 - source address keeps bits 31:2, bits 1:0 fixed at zero
// RULE3 - second address and length set queues a request behind the first
// RULE4 - enable set with nonzero count runs a transfer, else buffer idles
// RULE5 - hardware clears enable when the transfer completes
// RULE6 - swap bit set reverses byte order of each word fetched
// RULE7 - word count comes from the low sixteen bits of length
// RULE8 - reserved length bits 30:29 and 27:16 ignore writes, read zero
// RULE9 - first buffer has same layout at the preceding three offsets
// RULE10 - only the AHB side writes; PCI side reads only
// RULE11 - enabled buffers served one at a time, first buffer first
`ifndef PABDMA_REGS_SVH
`define PABDMA_REGS_SVH

`define PABDMA_BUF0_DST_OFS   32'hC000_0058
`define PABDMA_BUF0_SRC_OFS   32'hC000_005C
`define PABDMA_BUF0_LEN_OFS   32'hC000_0060
`define PABDMA_BUF1_DST_OFS   32'hC000_0064
`define PABDMA_BUF1_SRC_OFS   32'hC000_0068
`define PABDMA_BUF1_LEN_OFS   32'hC000_006C

`define PABDMA_EN_BIT         31
`define PABDMA_SWAP_BIT       28
`define PABDMA_CNT_MSB        15
`define PABDMA_ADDR_LSB       2

`define PABDMA_ADDR_RESET     30'h0000_0000
`define PABDMA_CNT_RESET      16'h0000
`define PABDMA_WORD_BYTES     32'h0000_0004

`endif

// >>> tb_pabdma_ctrl.sv
/*
 * Self-checking bench for pabdma_ctrl: register map, transfers, queueing.
 * Assumes pabdma_mem as far side and the bound checker.
 */
`default_nettype none
module tb_pabdma_ctrl
   import pabdma_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [31:0] BASE = 32'hC000_0058;
   localparam logic [31:0] B1   = 32'hC000_0064;
   logic             clk = 1'b0;
   logic             nrst = 1'b0;
   logic             sel = 1'b0;
   logic             wr = 1'b0;
   logic             psel = 1'b0;
   logic [31:0]      addr = '0;
   logic [31:0]      wd = '0;
   logic [31:0]      paddr = '0;
   logic [1:0]       stall = '0;
   logic [31:0]      ard, prd, fd;
   logic             prv, fv, fr, dv, dr, sv, sr, busy, ab;
   logic             ard_chk = 1'b0;
   logic [15:0]      n;
   pabdma_fetch_type fa;
   pabdma_store_type st;
   logic [31:0]      qa[$], qp[$];
   pabdma_store_type qs[$];
   int               num_errors = 0;
   int               n_compared = 0;
   int               seed = 98;

   always #5 clk = ~clk;
   always @(posedge clk) stall <= 2'($random(seed));

   pabdma_ctrl DUT (.I_CLOCK(clk), .I_NRST(nrst), .I_AHB_SEL(sel),
      .I_AHB_WRITE(wr), .I_AHB_ADDR(addr), .I_AHB_WDATA(wd),
      .O_AHB_RDATA(ard), .I_PCI_SEL(psel), .I_PCI_ADDR(paddr),
      .O_PCI_RDATA(prd), .O_PCI_RVALID(prv), .O_FETCH_VALID(fv),
      .O_FETCH(fa), .I_FETCH_READY(fr), .I_FETCH_DVALID(dv),
      .I_FETCH_DATA(fd), .O_FETCH_DREADY(dr), .O_STORE_VALID(sv),
      .O_STORE(st), .I_STORE_READY(sr), .O_BUSY(busy),
      .O_ACTIVE_BUF(ab));
   pabdma_mem MEM (.i_clk(clk), .i_nrst(nrst), .i_stall(stall),
      .i_fvalid(fv), .i_faddr(fa.addr), .o_fready(fr), .o_dvalid(dv),
      .o_data(fd), .i_dready(dr), .o_sready(sr));

   task automatic chk(input logic [63:0] got, input logic [63:0] exp);
      n_compared++;
      if (got !== exp) begin
         num_errors++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   always @(posedge clk) ard_chk <= sel && !wr;
   always @(negedge clk) begin
      if (ard_chk) chk(ard, qa.pop_front());
      if (prv) chk(prd, qp.pop_front());
      if (sv && sr) chk(st, qs.pop_front());
   end

   task automatic wr_reg(input logic [31:0] a, input logic [31:0] d);
      @(posedge clk);
      sel <= 1'b1;
      wr <= 1'b1;
      addr <= a;
      wd <= d;
      @(posedge clk);
      sel <= 1'b0;
   endtask

   // same register read from the ahb side, then the pci side
   task automatic rd2(input logic [31:0] a, input logic [31:0] e);
      qa.push_back(e);
      @(posedge clk);
      sel <= 1'b1;
      wr <= 1'b0;
      addr <= a;
      @(posedge clk);
      sel <= 1'b0;
      qp.push_back(e);
      psel <= 1'b1;
      paddr <= a;
      @(posedge clk);
      psel <= 1'b0;
   endtask

   function automatic logic [31:0] wfn(input logic [31:0] a, input logic s);
      wfn = {~a[15:0], a[15:0]};
      if (s)
         wfn = {wfn[7:0], wfn[15:8], wfn[23:16], wfn[31:24]};
   endfunction

   task automatic prog(input logic b, input logic s, input logic [15:0] c);
      logic [31:0] d, r, o;
      d = $random(seed) & 32'hFFFF_FFF0;
      r = $random(seed) & 32'hFFFF_FFF0;
      o = b ? B1 : BASE;
      wr_reg(o, d | 32'h0000_0003);
      wr_reg(o + 32'h0000_0004, r | 32'h0000_0003);
      for (int k = 0; k < c; k++)
         qs.push_back({d + 32'(4 * k), wfn(r + 32'(4 * k), s)});
      wr_reg(o + 32'h0000_0008, {3'b111, s, 12'hFFF, c});
   endtask

   task automatic drain();
      int t;
      t = 0;
      while ((busy !== 1'b0 || qs.size() != 0) && t < 3000) begin
         @(posedge clk);
         t++;
      end
      if (t >= 3000)
         num_errors++;
   endtask

   task automatic results();
      $display("errors=%0d compared=%0d", num_errors, n_compared);
      if (num_errors == 0 && n_compared > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   initial begin
      repeat (12) @(posedge clk);
      nrst <= 1'b1;
      for (int i = 0; i < 7; i++)
         rd2(BASE + 32'(4 * i), 32'h0000_0000);
      wr_reg(32'hC000_0070, 32'hFFFF_FFFF);
      wr_reg(B1, 32'hFFFF_FFFF);
      wr_reg(B1 + 32'h0000_0004, 32'hFFFF_FFFF);
      wr_reg(B1 + 32'h0000_0008, 32'h7FFF_FFFF);
      rd2(B1, 32'hFFFF_FFFC);
      rd2(B1 + 32'h0000_0004, 32'hFFFF_FFFC);
      rd2(B1 + 32'h0000_0008, 32'h1000_FFFF);
      rd2(32'hC000_0070, 32'h0000_0000);
      chk(busy, 1'b0);
      wr_reg(B1 + 32'h0000_0008, 32'h8000_0000);
      rd2(B1 + 32'h0000_0008, 32'h0000_0000);
      for (int i = 0; i < 4; i++) begin
         n = 16'(1 + ($random(seed) & 7));
         prog(i[1], i[0], n);
         drain();
         rd2(i[1] ? 32'hC000_006C : 32'hC000_0060,
            {3'b000, i[0], 12'h000, n});
         chk(ab, i[1]);
      end
      // long first run keeps buffer 0 busy while buffer 1 is armed
      prog(1'b0, 1'b1, 16'h0008);
      prog(1'b1, 1'b0, 16'h0002);
      @(negedge clk);
      chk(busy, 1'b1);
      chk(ab, 1'b0);
      drain();
      rd2(32'hC000_0060, 32'h1000_0008);
      rd2(32'hC000_006C, 32'h0000_0002);
      results();
   end

   initial begin
      #200000;
      num_errors++;
      results();
   end
endmodule
`default_nettype wire
